//--- src/i2sf_status.sv
// Status flag register of the serial bus controller with its register slave
`timescale 1ns/1ps
`include "i2sf_defs.svh"
module i2sf_status
	import i2sf_pkg::*;
#(
	parameter int START_HOLD_CYC = `I2SF_START_HOLD_CYC
)
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [`I2SF_ADDR_W-1:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [31:0] WRITEDATA,
	output logic [31:0] READDATA,
	output logic WAITREQUEST,
	output logic IRQ,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic ARB_LOST,
	input wire logic [3:0] LOW_FLAGS
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic done;
	logic req;
	logic acc_write;
	logic acc_read;
	logic hit_status;
	logic hit_bitwin;
	logic status_read;
	i2sf_byte_t status;
	i2sf_byte_t own_addr;
	logic master_active_flag;
	logic arb_lost_flag;
	logic ext_code_flag;
	logic addr_match_flag;
	logic [3:0] low_flags;
	logic unit_enable_bit;
	logic start_request_bit;
	logic exit_pulse;
	logic enable_fall;
	logic [`I2SF_IRQ_W-1:0] irq_stat;
	logic [`I2SF_IRQ_W-1:0] irq_mask;
	logic [`I2SF_IRQ_W-1:0] events;
	logic start_det;
	logic stop_det;
	logic eighth_rise;
	i2sf_byte_t addr_byte;
	logic bus_busy;
	logic gen_oe;
	logic started;
	logic arb_event;
	logic ext_hit;
	logic match_hit;
	logic [31:0] next_readdata;

	// ----------------------------------------
	// Bus line monitor and start generator
	// ----------------------------------------
	i2sf_line_monitor u_monitor (
		.clk(CLK),
		.rst(RST),
		.scl_in(SCL_IN),
		.sda_in(SDA_IN),
		.start_det(start_det),
		.stop_det(stop_det),
		.eighth_rise(eighth_rise),
		.addr_byte(addr_byte),
		.bus_busy(bus_busy)
	);

	// Start only when enabled, requested, not master and the bus is free
	i2sf_start_gen #(
		.HOLD_CYC(START_HOLD_CYC)
	) u_start (
		.clk(CLK),
		.rst(RST),
		.go(start_request_bit & unit_enable_bit & ~master_active_flag & ~bus_busy),
		.abort(~unit_enable_bit | exit_pulse),
		.sda_oe(gen_oe),
		.started(started)
	);

	// Open-drain data line: only ever pulled low
	assign SDA_OUT = 1'b0;
	assign SDA_OE = gen_oe;

	// ----------------------------------------
	// Avalon-MM slave handshake
	// ----------------------------------------
	// One wait state: the request is taken in the cycle after it appears
	assign req = READ | WRITE;
	assign WAITREQUEST = req & ~done;
	assign acc_write = WRITE & done;
	assign acc_read = READ & done;

	always_ff @(posedge CLK)
	begin
		if (RST)
			done <= 1'b0;
		else
			done <= req & ~done;
	end

	assign hit_status = (ADDRESS == `I2SF_STATUS_IDX);
	assign hit_bitwin = (ADDRESS >= `I2SF_BITWIN_BASE) && (ADDRESS <= `I2SF_BITWIN_LAST);
	// Whole-register and single-bit reads both count as status reads
	assign status_read = acc_read & (hit_status | hit_bitwin);

	// ----------------------------------------
	// Status assembly
	// ----------------------------------------
	assign status = {master_active_flag, arb_lost_flag, ext_code_flag, addr_match_flag,
		low_flags};

	// Read data mux, captured in the first request cycle
	always_comb
	begin
		next_readdata = 32'h00000000;
		if (hit_status)
			next_readdata = {24'h000000, status};
		else if (hit_bitwin)
			next_readdata = {31'h00000000, status[ADDRESS[2:0]]};
		else if (ADDRESS == `I2SF_CTRL_IDX)
			next_readdata = {24'h000000, unit_enable_bit, 5'h00, start_request_bit, 1'b0};
		else if (ADDRESS == `I2SF_OWN_ADDR_IDX)
			next_readdata = {24'h000000, own_addr};
		else if (ADDRESS == `I2SF_IRQ_STAT_IDX)
			next_readdata = {27'h0000000, irq_stat};
		else if (ADDRESS == `I2SF_IRQ_MASK_IDX)
			next_readdata = {27'h0000000, irq_mask};
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
			READDATA <= 32'h00000000;
		else if (READ && !done)
			READDATA <= next_readdata;
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	// Enable and start request; exit bit is a write-one pulse reading zero
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			unit_enable_bit <= 1'(`I2SF_CTRL_RESET >> `I2SF_CT_ENABLE);
			start_request_bit <= 1'b0;
			exit_pulse <= 1'b0;
		end
		else
		begin
			exit_pulse <= 1'b0;
			if (acc_write && ADDRESS == `I2SF_CTRL_IDX)
			begin
				unit_enable_bit <= WRITEDATA[`I2SF_CT_ENABLE];
				exit_pulse <= WRITEDATA[`I2SF_CT_EXIT];
				if (WRITEDATA[`I2SF_CT_START])
					start_request_bit <= 1'b1;
			end
			if (started || arb_event || stop_det || exit_pulse || !unit_enable_bit)
				start_request_bit <= 1'b0;
		end
	end

	// Falling edge of enable, decoded from a control write that clears the set enable bit
	always_ff @(posedge CLK)
	begin
		if (RST)
			enable_fall <= 1'b0;
		else
			enable_fall <= acc_write && ADDRESS == `I2SF_CTRL_IDX
				&& unit_enable_bit && !WRITEDATA[`I2SF_CT_ENABLE];
	end

	// Own slave address
	always_ff @(posedge CLK)
	begin
		if (RST)
			own_addr <= `I2SF_OWN_ADDR_RESET;
		else if (acc_write && ADDRESS == `I2SF_OWN_ADDR_IDX)
			own_addr <= WRITEDATA[7:0];
	end

	// ----------------------------------------
	// Flag logic
	// ----------------------------------------
	// Arbitration loss only counts while master
	assign arb_event = ARB_LOST & master_active_flag;
	assign ext_hit = eighth_rise && (addr_byte[7:4] == `I2SF_EXT_LOW
		|| addr_byte[7:4] == `I2SF_EXT_HIGH);
	assign match_hit = eighth_rise && (addr_byte[7:1] == own_addr[7:1]);

	// Master flag: set by own start, cleared by stop, loss, exit, disable; set wins
	always_ff @(posedge CLK)
	begin
		if (RST)
			master_active_flag <= 1'b0;
		else if (started)
			master_active_flag <= 1'b1;
		else if (stop_det || arb_event || exit_pulse || enable_fall)
			master_active_flag <= 1'b0;
	end

	// Arbitration flag: a loss in the read cycle wins over the read clear
	always_ff @(posedge CLK)
	begin
		if (RST)
			arb_lost_flag <= 1'b0;
		else if (arb_event)
			arb_lost_flag <= 1'b1;
		else if (status_read || enable_fall)
			arb_lost_flag <= 1'b0;
	end

	// Extension code flag: eighth clock of the address byte wins over clears
	always_ff @(posedge CLK)
	begin
		if (RST)
			ext_code_flag <= 1'b0;
		else if (ext_hit)
			ext_code_flag <= 1'b1;
		else if (start_det || stop_det || exit_pulse || enable_fall)
			ext_code_flag <= 1'b0;
	end

	// Address match flag
	always_ff @(posedge CLK)
	begin
		if (RST)
			addr_match_flag <= 1'b0;
		else if (match_hit)
			addr_match_flag <= 1'b1;
		else if (start_det || stop_det || exit_pulse || enable_fall)
			addr_match_flag <= 1'b0;
	end

	// Low four flags mirrored from the transfer engine
	always_ff @(posedge CLK)
	begin
		if (RST)
			low_flags <= 4'(`I2SF_STATUS_RESET >> 4);
		else
			low_flags <= LOW_FLAGS;
	end

	// Writes to the status index fall through with no effect
	// (no branch above names the status index for writing)

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	always_comb
	begin
		events = '0;
		events[`I2SF_EV_START] = started;
		events[`I2SF_EV_ARB] = arb_event;
		events[`I2SF_EV_EXT] = ext_hit;
		events[`I2SF_EV_MATCH] = match_hit;
		events[`I2SF_EV_STOP] = stop_det;
	end

	// Sticky event bits, cleared by reading them; a new event wins
	always_ff @(posedge CLK)
	begin
		if (RST)
			irq_stat <= '0;
		else if (acc_read && ADDRESS == `I2SF_IRQ_STAT_IDX)
			irq_stat <= events;
		else
			irq_stat <= irq_stat | events;
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
			irq_mask <= '0;
		else if (acc_write && ADDRESS == `I2SF_IRQ_MASK_IDX)
			irq_mask <= WRITEDATA[`I2SF_IRQ_W-1:0];
	end

	// Level interrupt while any unmasked event is pending
	always_ff @(posedge CLK)
	begin
		if (RST)
			IRQ <= 1'b0;
		else
			IRQ <= |(irq_stat & irq_mask);
	end
endmodule

//--- src/i2sf_defs.svh
// Register indices, field positions, reset values and timing counts of the status flag block
`ifndef I2SF_DEFS_SVH
`define I2SF_DEFS_SVH

// ----------------------------------------
// Register word indices (word addressed)
// ----------------------------------------
`define I2SF_ADDR_W 20
`define I2SF_STATUS_IDX 20'hFFF56
`define I2SF_CTRL_IDX 20'hFFF50
`define I2SF_OWN_ADDR_IDX 20'hFFF51
`define I2SF_IRQ_STAT_IDX 20'hFFF58
`define I2SF_IRQ_MASK_IDX 20'hFFF59
`define I2SF_BITWIN_BASE 20'hFFF60
`define I2SF_BITWIN_LAST 20'hFFF67

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define I2SF_ST_MASTER 7
`define I2SF_ST_ARB 6
`define I2SF_ST_EXT 5
`define I2SF_ST_MATCH 4
`define I2SF_ST_LOW_MSB 3
`define I2SF_STATUS_RESET 8'h00

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define I2SF_CT_ENABLE 7
`define I2SF_CT_EXIT 6
`define I2SF_CT_START 1
`define I2SF_CTRL_RESET 8'h00
`define I2SF_OWN_ADDR_RESET 8'h00

// ----------------------------------------
// Interrupt event bits
// ----------------------------------------
`define I2SF_IRQ_W 5
`define I2SF_EV_START 0
`define I2SF_EV_ARB 1
`define I2SF_EV_EXT 2
`define I2SF_EV_MATCH 3
`define I2SF_EV_STOP 4

// ----------------------------------------
// Address byte decoding
// ----------------------------------------
`define I2SF_EXT_LOW 4'h0
`define I2SF_EXT_HIGH 4'hF
`define I2SF_ADDR_LAST_BIT 4'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define I2SF_CLK_PERIOD_NS 4
`define I2SF_START_HOLD_NS 4000
`define I2SF_START_HOLD_CYC ((`I2SF_START_HOLD_NS + `I2SF_CLK_PERIOD_NS - 1) / `I2SF_CLK_PERIOD_NS)

`endif

//--- src/i2sf_pkg.sv
// Types shared by the status flag block
package i2sf_pkg;
	typedef enum logic {I2SF_GEN_IDLE, I2SF_GEN_HOLD} i2sf_gen_state_t;
	typedef logic [7:0] i2sf_byte_t;
endpackage

//--- src/i2sf_line_monitor.sv
// Bus line sampler: start, stop and address byte capture on the serial lines
`timescale 1ns/1ps
`include "i2sf_defs.svh"
module i2sf_line_monitor
	import i2sf_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic start_det,
	output logic stop_det,
	output logic eighth_rise,
	output i2sf_byte_t addr_byte,
	output logic bus_busy
);
	logic scl_s1, scl_s2, scl_s3;
	logic sda_s1, sda_s2, sda_s3;
	logic addr_phase;
	logic [3:0] bit_cnt;
	logic [6:0] shift;
	logic scl_rise;

	// ----------------------------------------
	// Synchronisers and edge history
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			{scl_s1, scl_s2, scl_s3} <= 3'h7;
			{sda_s1, sda_s2, sda_s3} <= 3'h7;
		end
		else
		begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
		end
	end

	// Conditions seen while the clock line is high
	assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
	assign stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
	assign scl_rise = scl_s2 & ~scl_s3;

	// Bus busy from start to stop
	always_ff @(posedge clk)
	begin
		if (rst || stop_det)
			bus_busy <= 1'b0;
		else if (start_det)
			bus_busy <= 1'b1;
	end

	// First byte after a start is shifted in and flagged at its eighth clock
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			addr_phase <= 1'b0;
			bit_cnt <= 4'h0;
			shift <= 7'h00;
			addr_byte <= 8'h00;
			eighth_rise <= 1'b0;
		end
		else
		begin
			eighth_rise <= 1'b0;
			if (start_det)
			begin
				addr_phase <= 1'b1;
				bit_cnt <= 4'h0;
			end
			else if (stop_det)
				addr_phase <= 1'b0;
			else if (addr_phase && scl_rise)
			begin
				shift <= {shift[5:0], sda_s2};
				bit_cnt <= bit_cnt + 4'h1;
				if (bit_cnt == `I2SF_ADDR_LAST_BIT)
				begin
					addr_byte <= {shift, sda_s2};
					eighth_rise <= 1'b1;
					addr_phase <= 1'b0;
				end
			end
		end
	end
endmodule

//--- src/i2sf_start_gen.sv
// Start condition generator: pulls the data line low for the hold time, without sampling the clock line
`timescale 1ns/1ps
`include "i2sf_defs.svh"
module i2sf_start_gen
	import i2sf_pkg::*;
#(
	parameter int HOLD_CYC = `I2SF_START_HOLD_CYC
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic abort,
	output logic sda_oe,
	output logic started
);
	i2sf_gen_state_t state;
	logic [15:0] cnt;

	// Hold the data line low for the start hold time, then report the start
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= I2SF_GEN_IDLE;
			cnt <= 16'h0000;
			sda_oe <= 1'b0;
			started <= 1'b0;
		end
		else
		begin
			started <= 1'b0;
			unique case (state)
				I2SF_GEN_IDLE:
				begin
					if (go && !abort)
					begin
						state <= I2SF_GEN_HOLD;
						sda_oe <= 1'b1;
						cnt <= 16'h0000;
					end
				end
				I2SF_GEN_HOLD:
				begin
					if (abort)
					begin
						state <= I2SF_GEN_IDLE;
						sda_oe <= 1'b0;
					end
					else if (cnt == 16'(HOLD_CYC - 1))
					begin
						state <= I2SF_GEN_IDLE;
						sda_oe <= 1'b0;
						started <= 1'b1;
					end
					else
						cnt <= cnt + 16'h0001;
				end
			endcase
		end
	end
endmodule

//--- bench/i2sf_bus_model.sv
// Other bus party: drives the serial lines open drain
`timescale 1ns/1ps
module i2sf_bus_model
(
	input wire logic dut_oe,
	output logic scl_low,
	output logic sda_low
);
	localparam realtime HALF = 62.5;
	initial
	begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	// Engine stand-in: holds the clock low after the block's own start
	always @(posedge dut_oe)
	begin
		#60 scl_low = 1'b1;
	end
	// Start or repeated start from any line state
	task automatic start();
		sda_low = 1'b0;
		#HALF scl_low = 1'b0;
		#HALF sda_low = 1'b1;
		#HALF scl_low = 1'b1;
	endtask
	// Address byte, most significant bit first, then a released ninth bit
	task automatic send(input logic [7:0] b);
		int i;
		for (i = 7; i >= -1; i--)
		begin
			sda_low = (i >= 0) ? !b[i & 7] : 1'b0;
			#HALF scl_low = 1'b0;
			#HALF scl_low = 1'b1;
		end
	endtask
	// Stop: data rises while the clock is high
	task automatic stop();
		sda_low = 1'b1;
		#HALF scl_low = 1'b0;
		#HALF sda_low = 1'b0;
	endtask
endmodule

//--- bench/i2sf_status_checker.sv
// Concurrent checks on the ports of the status flag block
`timescale 1ns/1ps
`include "i2sf_defs.svh"
module i2sf_status_checker
	import i2sf_pkg::*;
#(
	parameter int START_HOLD_CYC = `I2SF_START_HOLD_CYC
)
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [`I2SF_ADDR_W-1:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [31:0] WRITEDATA,
	input wire logic [31:0] READDATA,
	input wire logic WAITREQUEST,
	input wire logic IRQ,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic ARB_LOST,
	input wire logic [3:0] LOW_FLAGS
);
	// ----------------------------------------
	// Accepted reads
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	wire logic acc = READ && !WAITREQUEST;
	wire logic rd_st = acc && ADDRESS == `I2SF_STATUS_IDX;
	wire logic rd_bw = acc && ADDRESS >= `I2SF_BITWIN_BASE && ADDRESS <= `I2SF_BITWIN_LAST;
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_reset_zero: assert property (disable iff (1'b0)
		RST |=> READDATA == 32'h0 && !IRQ && !SDA_OE) else $error("reset left outputs set");
	a_wait_one: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
		else $error("wait longer than one cycle");
	a_status_width: assert property (rd_st |-> READDATA[31:8] == 24'h0)
		else $error("status upper bits set");
	a_arb_master: assert property (rd_st && READDATA[6] |-> !READDATA[7])
		else $error("master flag set beside arbitration loss");
	a_bit_window: assert property (rd_bw |-> READDATA[31:1] == 31'h0)
		else $error("bit window read wider than one bit");
	a_start_scl: assert property ($rose(SDA_OE) |-> SCL_IN)
		else $error("start pulled while clock low");
	a_start_hold: assert property ($rose(SDA_OE) |-> SDA_OE [*4])
		else $error("start pull too short");
	a_open_drain: assert property (SDA_OUT == 1'b0)
		else $error("data line driven high");
	c_master: cover property (rd_st && READDATA[7]);
	c_arb: cover property (rd_st && READDATA[6]);
	c_ext: cover property (rd_st && READDATA[5]);
	c_irq: cover property ($rose(IRQ));
endmodule
bind i2sf_status i2sf_status_checker #(.START_HOLD_CYC(START_HOLD_CYC)) u_chk (.CLK(CLK),
	.RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
	.READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .IRQ(IRQ), .SCL_IN(SCL_IN),
	.SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ARB_LOST(ARB_LOST),
	.LOW_FLAGS(LOW_FLAGS));

//--- bench/tb.sv
// Self-checking bench of the status flag block
`timescale 1ns/1ps
`include "i2sf_defs.svh"
module tb
	import i2sf_pkg::*;
;
	typedef struct packed {logic w; logic [19:0] a; logic [31:0] d;} i2sf_row_t;
	localparam i2sf_row_t ROWS [11] = '{'{1'b0, `I2SF_STATUS_IDX, 32'h0},
		'{1'b0, `I2SF_CTRL_IDX, 32'h0}, '{1'b0, `I2SF_OWN_ADDR_IDX, 32'h0},
		'{1'b0, `I2SF_IRQ_MASK_IDX, 32'h0}, '{1'b1, `I2SF_STATUS_IDX, 32'hFF},
		'{1'b1, `I2SF_BITWIN_BASE, 32'hFF}, '{1'b0, `I2SF_STATUS_IDX, 32'h0},
		'{1'b1, `I2SF_OWN_ADDR_IDX, 32'hA4}, '{1'b1, `I2SF_IRQ_MASK_IDX, 32'h1F},
		'{1'b1, `I2SF_CTRL_IDX, 32'h80}, '{1'b0, 20'h00000, 32'h0}};
	logic [7:0] bt [4] = '{8'h0E, 8'hF0, 8'h52, 8'hA4};
	logic [7:0] be [4] = '{8'h20, 8'h20, 8'h00, 8'h10};
	logic CLK, RST, READ, WRITE, ARB_LOST, WAITREQUEST, IRQ, SDA_OUT, SDA_OE;
	logic scl_low, sda_low, scl, sda;
	logic [19:0] ADDRESS;
	logic [31:0] WRITEDATA, READDATA, q;
	logic [3:0] LOW_FLAGS;
	int err_count, n_checks, k;
	// Open-drain lines with pull-ups
	assign scl = !scl_low;
	assign sda = !(sda_low || SDA_OE);
	i2sf_status #(.START_HOLD_CYC(40)) dut (.CLK(CLK), .RST(RST), .ADDRESS(ADDRESS),
		.READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
		.WAITREQUEST(WAITREQUEST), .IRQ(IRQ), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT),
		.SDA_OE(SDA_OE), .ARB_LOST(ARB_LOST), .LOW_FLAGS(LOW_FLAGS));
	i2sf_bus_model u_bus (.dut_oe(SDA_OE), .scl_low(scl_low), .sda_low(sda_low));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One Avalon transfer; read data lands in q at the accepting edge
	task automatic bus(input logic w, input logic [19:0] a, input logic [31:0] d);
		int i;
		// Idle edges let line events and their flag clears settle first
		repeat (3) @(posedge CLK);
		READ <= !w;
		WRITE <= w;
		ADDRESS <= a;
		WRITEDATA <= d;
		for (i = 0; i < 20; i++)
		begin
			@(posedge CLK);
			if (WAITREQUEST === 1'b0)
				break;
		end
		if (i == 20)
		begin
			err_count++;
			test_done();
		end
		q = READDATA;
		READ <= 1'b0;
		WRITE <= 1'b0;
	endtask
	// Requests a start and waits for the pull to end
	task automatic start_dev();
		int i;
		bus(1'b1, `I2SF_CTRL_IDX, 32'h82);
		for (i = 0; i < 400 && SDA_OE !== 1'b1; i++)
			@(posedge CLK);
		// Status read while the start request waits on the pull
		bus(1'b0, `I2SF_STATUS_IDX, 32'h0);
		chk(q, 32'h0);
		for (; i < 400 && SDA_OE !== 1'b0; i++)
			@(posedge CLK);
		if (i == 400)
		begin
			err_count++;
			test_done();
		end
	endtask
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial
	begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	initial
	begin
		repeat (100000) @(posedge CLK);
		err_count++;
		test_done();
	end
	initial
	begin
		{RST, READ, WRITE, ARB_LOST, ADDRESS, WRITEDATA, LOW_FLAGS} = {1'b1, 59'h0};
		err_count = 0;
		n_checks = 0;
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		// Reset values, refused writes, set-up writes, unmapped read
		for (k = 0; k < 11; k++)
		begin
			bus(ROWS[k].w, ROWS[k].a, ROWS[k].d);
			if (!ROWS[k].w)
				chk(q, ROWS[k].d);
		end
		LOW_FLAGS <= 4'hA;
		bus(1'b0, `I2SF_STATUS_IDX, 32'h0);
		chk(q, 32'h0A);
		for (k = 0; k < 4; k++)
		begin
			bus(1'b0, `I2SF_BITWIN_BASE + k[19:0], 32'h0);
			chk(q, {31'h0, k[0]});
		end
		LOW_FLAGS <= 4'h0;
		// Own start, interrupt raise and clear
		start_dev();
		bus(1'b0, `I2SF_STATUS_IDX, 32'h0);
		chk(q, 32'h80);
		chk({31'h0, IRQ}, 32'h1);
		bus(1'b0, `I2SF_IRQ_STAT_IDX, 32'h0);
		chk(q, 32'h01);
		bus(1'b0, `I2SF_STATUS_IDX, 32'h0);
		chk({31'h0, IRQ}, 32'h0);
		u_bus.stop();
		// Every way of clearing master and arbitration flags
		for (k = 0; k < 6; k++)
		begin
			start_dev();
			if (k > 2)
			begin
				ARB_LOST <= 1'b1;
				@(posedge CLK);
				ARB_LOST <= 1'b0;
			end
			case (k)
				0: bus(1'b1, `I2SF_CTRL_IDX, 32'hC0);
				2: u_bus.stop();
				3:
				begin
					bus(1'b0, `I2SF_STATUS_IDX, 32'h0);
					chk(q, 32'h40);
				end
				4: bus(1'b0, `I2SF_BITWIN_BASE + 20'h1, 32'h0);
				default:
				begin
					bus(1'b1, `I2SF_CTRL_IDX, 32'h0);
					bus(1'b1, `I2SF_CTRL_IDX, 32'h80);
				end
			endcase
			bus(1'b0, `I2SF_STATUS_IDX, 32'h0);
			chk(q, 32'h0);
			if (k != 2)
				u_bus.stop();
		end
		// Masked match event, then clear by repeated start
		bus(1'b0, `I2SF_IRQ_STAT_IDX, 32'h0);
		bus(1'b1, `I2SF_IRQ_MASK_IDX, 32'h0);
		u_bus.start();
		u_bus.send(8'hA5);
		bus(1'b0, `I2SF_STATUS_IDX, 32'h0);
		chk(q, 32'h10);
		chk({31'h0, IRQ}, 32'h0);
		bus(1'b0, `I2SF_IRQ_STAT_IDX, 32'h0);
		chk(q, 32'h08);
		u_bus.start();
		bus(1'b0, `I2SF_STATUS_IDX, 32'h0);
		chk(q, 32'h0);
		// Address bytes from the other party, cleared by stop or exit
		for (k = 0; k < 4; k++)
		begin
			u_bus.start();
			u_bus.send(bt[k]);
			bus(1'b0, `I2SF_STATUS_IDX, 32'h0);
			chk(q, {24'h0, be[k]});
			if (k[0])
				bus(1'b1, `I2SF_CTRL_IDX, 32'hC0);
			else
				u_bus.stop();
			bus(1'b0, `I2SF_STATUS_IDX, 32'h0);
			chk(q, 32'h0);
			if (k[0])
				u_bus.stop();
		end
		// Mid-run reset with the extension flag set
		u_bus.start();
		u_bus.send(8'h0E);
		bus(1'b0, `I2SF_STATUS_IDX, 32'h0);
		chk(q, 32'h20);
		RST <= 1'b1;
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		bus(1'b0, `I2SF_STATUS_IDX, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, `I2SF_IRQ_STAT_IDX, 32'h0);
		chk(q, 32'h0);
		test_done();
	end
endmodule
